// >>> core/acr_pkg.sv
// acr_pkg: offsets, field layout, reset values and codes for the channel config bank
// assumes: Avalon-MM 32-bit data, byte addresses, 16-bit registers in the low lanes
package acr_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int ACR_ADDR_W = 8;
  localparam logic [7:0] ACR_OFS_GAIN_LO = 8'h10;
  localparam logic [7:0] ACR_OFS_GAIN_HI = 8'h12;
  localparam logic [7:0] ACR_OFS_CUT_LO = 8'h14;
  localparam logic [7:0] ACR_OFS_CUT_HI = 8'h16;
  localparam logic [7:0] ACR_OFS_BUF_SIZE = 8'h18;
  localparam int ACR_REG_W = 16;

  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int ACR_CODE_W = 2;
  localparam int ACR_CH_PER_REG = 8;
  localparam int ACR_BS_W = 5;
  localparam logic [15:0] ACR_RST_GAIN = 16'h0000;
  localparam logic [15:0] ACR_RST_CUT = 16'h0000;
  localparam logic [4:0] ACR_RST_BS = 5'h00;
  localparam logic [4:0] ACR_BS_MAX = 5'h16;
  localparam int ACR_WAIT_CYC = 1;

  // ----------------------------------------------------------------
  // decoded settings, one-hot
  // ----------------------------------------------------------------
  localparam logic [3:0] ACR_GAIN_X1 = 4'h1;
  localparam logic [3:0] ACR_GAIN_X10 = 4'h2;
  localparam logic [3:0] ACR_GAIN_X100 = 4'h4;
  localparam logic [3:0] ACR_GAIN_X1000 = 4'h8;
  localparam logic [3:0] ACR_CUT_1000HZ = 4'h1;
  localparam logic [3:0] ACR_CUT_100HZ = 4'h2;
  localparam logic [3:0] ACR_CUT_10HZ = 4'h4;
  localparam logic [3:0] ACR_CUT_1HZ = 4'h8;

  typedef enum logic [1:0] {ACR_G1, ACR_G10, ACR_G100, ACR_G1000} acr_gain_code_t;

endpackage

// >>> core/acr_dec_if.sv
// acr_dec_if: raw code words passed from register bank to decoder
// assumes: one clock domain, both ends on mclk_in
interface acr_dec_if;
  logic [15:0] gain_lo;
  logic [15:0] gain_hi;
  logic [15:0] cut_lo;
  logic [15:0] cut_hi;
  modport bank (output gain_lo, gain_hi, cut_lo, cut_hi);
  modport dec (input gain_lo, gain_hi, cut_lo, cut_hi);
endinterface

// >>> core/acr_decode.sv
// acr_decode: registered one-hot gain and cutoff selects per channel
// assumes: codes come from the register bank on the same clock
module acr_decode
  import acr_pkg::*;
#(
  parameter int NUM_CH = 16
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_b_in,
  // codes
  acr_dec_if.dec codes,
  // front end selects
  output logic [4*NUM_CH-1:0] gain_sel_out,
  output logic [4*NUM_CH-1:0] cutoff_sel_out
);

  if (NUM_CH != 2 * ACR_CH_PER_REG) begin : g_bad_num_ch
    $error("acr_decode: NUM_CH must be 16");
  end

  logic [31:0] gain_all;
  logic [31:0] cut_all;
  assign gain_all = {codes.gain_hi, codes.gain_lo};
  assign cut_all = {codes.cut_hi, codes.cut_lo};

  // ----------------------------------------------------------------
  // per channel decode
  // ----------------------------------------------------------------
  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
        gain_sel_out[4*ch +: 4] <= ACR_GAIN_X1;
        cutoff_sel_out[4*ch +: 4] <= ACR_CUT_1000HZ;
      end else begin
        case (gain_all[2*ch +: 2])
          2'h0: gain_sel_out[4*ch +: 4] <= ACR_GAIN_X1;
          2'h1: gain_sel_out[4*ch +: 4] <= ACR_GAIN_X10;
          2'h2: gain_sel_out[4*ch +: 4] <= ACR_GAIN_X100;
          default: gain_sel_out[4*ch +: 4] <= ACR_GAIN_X1000;
        endcase
        case (cut_all[2*ch +: 2])
          2'h0: cutoff_sel_out[4*ch +: 4] <= ACR_CUT_1000HZ;
          2'h1: cutoff_sel_out[4*ch +: 4] <= ACR_CUT_100HZ;
          2'h2: cutoff_sel_out[4*ch +: 4] <= ACR_CUT_10HZ;
          default: cutoff_sel_out[4*ch +: 4] <= ACR_CUT_1HZ;
        endcase
      end
    end

    chk_gain_onehot: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      $past(gain_all[2*ch +: 2]) == 2'h3 |-> gain_sel_out[4*ch +: 4] == ACR_GAIN_X1000)
      else $error("gain decode wrong");
    chk_cut_decode: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
      1'b1 |=> cutoff_sel_out[4*ch +: 4] == (4'h1 << $past(cut_all[2*ch +: 2])))
      else $error("cutoff decode wrong");
  end

endmodule // acr_decode

// >>> core/acr_regs.sv
// acr_regs: channel gain, filter cutoff and buffer size registers
// assumes: Avalon-MM slave, 32-bit data, byte addresses, single 125 MHz clock
//
// How it works
// - gain_ch0_7 holds 2-bit codes, channels 0-7
// - gain_ch8_15 holds 2-bit codes, channels 8-15
// - gain codes decode to 1,10,100,1000
// - gain fields reset to 00
// - cutoff_ch0_7 holds 2-bit codes, channels 0-7
// - cutoff_ch8_15 holds 2-bit codes, channels 8-15
// - cutoff codes decode to 1000,100,10,1 Hz
// - cutoff fields reset to 00
// - buffer size is 2^code samples, codes 0-22
// - buffer size reads back last write
//
// The implementer's own choice: the Avalon-MM register port.
module acr_regs
  import acr_pkg::*;
(
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_b_in,
  // avalon-mm slave
  input wire logic [ACR_ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // front end
  output logic [63:0] gain_sel_out,
  output logic [63:0] cutoff_sel_out,
  // scan buffer
  output logic [4:0] buffer_size_code_out,
  output logic buffer_size_valid_out
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [15:0] gain_ch0_7_r;
  logic [15:0] gain_ch8_15_r;
  logic [15:0] cutoff_ch0_7_r;
  logic [15:0] cutoff_ch8_15_r;
  logic [15:0] sample_buffer_size_r;
  logic ack_r;
  logic [15:0] wr_nxt;
  logic req;
  logic wr_go;
  logic hit;
  logic [15:0] rd_nxt;

  assign req = avs_read_in | avs_write_in;
  assign wr_go = avs_write_in & ack_r;

  // ----------------------------------------------------------------
  // bus handshake: one wait cycle, answer on the second
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      avs_waitrequest_out <= 1'b1;
    end else begin
      avs_waitrequest_out <= ~(req & ~ack_r);
    end
  end

  // ----------------------------------------------------------------
  // write merge with byte lanes 0 and 1
  // ----------------------------------------------------------------
  always_comb begin
    rd_nxt = 16'h0000;
    hit = 1'b1;
    case (avs_address_in)
      ACR_OFS_GAIN_LO: rd_nxt = gain_ch0_7_r;
      ACR_OFS_GAIN_HI: rd_nxt = gain_ch8_15_r;
      ACR_OFS_CUT_LO: rd_nxt = cutoff_ch0_7_r;
      ACR_OFS_CUT_HI: rd_nxt = cutoff_ch8_15_r;
      ACR_OFS_BUF_SIZE: rd_nxt = sample_buffer_size_r;
      default: hit = 1'b0;
    endcase
    wr_nxt = rd_nxt;
    if (avs_byteenable_in[0]) begin
      wr_nxt[7:0] = avs_writedata_in[7:0];
    end
    if (avs_byteenable_in[1]) begin
      wr_nxt[15:8] = avs_writedata_in[15:8];
    end
  end

  // ----------------------------------------------------------------
  // gain registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      gain_ch0_7_r <= ACR_RST_GAIN;
      gain_ch8_15_r <= ACR_RST_GAIN;
    end else if (wr_go && avs_address_in == ACR_OFS_GAIN_LO) begin
      gain_ch0_7_r <= wr_nxt;
    end else if (wr_go && avs_address_in == ACR_OFS_GAIN_HI) begin
      gain_ch8_15_r <= wr_nxt;
    end
  end

  // ----------------------------------------------------------------
  // cutoff registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cutoff_ch0_7_r <= ACR_RST_CUT;
      cutoff_ch8_15_r <= ACR_RST_CUT;
    end else if (wr_go && avs_address_in == ACR_OFS_CUT_LO) begin
      cutoff_ch0_7_r <= wr_nxt;
    end else if (wr_go && avs_address_in == ACR_OFS_CUT_HI) begin
      cutoff_ch8_15_r <= wr_nxt;
    end
  end

  // ----------------------------------------------------------------
  // buffer size register, all 16 bits stored for readback
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sample_buffer_size_r <= {11'h000, ACR_RST_BS};
    end else if (wr_go && avs_address_in == ACR_OFS_BUF_SIZE) begin
      sample_buffer_size_r <= wr_nxt;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      buffer_size_code_out <= ACR_RST_BS;
      buffer_size_valid_out <= 1'b1;
    end else begin
      buffer_size_code_out <= sample_buffer_size_r[ACR_BS_W-1:0];
      buffer_size_valid_out <= sample_buffer_size_r[ACR_BS_W-1:0] <= ACR_BS_MAX;
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      avs_readdata_out <= 32'h0000_0000;
    end else if (avs_read_in && !ack_r) begin
      avs_readdata_out <= hit ? {16'h0000, rd_nxt} : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // decode to the front end
  // ----------------------------------------------------------------
  acr_dec_if dec_if ();
  assign dec_if.gain_lo = gain_ch0_7_r;
  assign dec_if.gain_hi = gain_ch8_15_r;
  assign dec_if.cut_lo = cutoff_ch0_7_r;
  assign dec_if.cut_hi = cutoff_ch8_15_r;

  acr_decode #(
    .NUM_CH(16)
  ) u_decode (
    .mclk_in(mclk_in),
    .rst_b_in(rst_b_in),
    .codes(dec_if),
    .gain_sel_out(gain_sel_out),
    .cutoff_sel_out(cutoff_sel_out)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_gain_lo_write: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    wr_go && avs_address_in == ACR_OFS_GAIN_LO && avs_byteenable_in[1:0] == 2'h3
    |=> gain_ch0_7_r == $past(avs_writedata_in[15:0]))
    else $error("gain_ch0_7 write lost");
  chk_gain_hi_write: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    wr_go && avs_address_in == ACR_OFS_GAIN_HI && avs_byteenable_in[1:0] == 2'h3
    |=> gain_ch8_15_r == $past(avs_writedata_in[15:0]))
    else $error("gain_ch8_15 write lost");
  chk_cut_lo_write: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    wr_go && avs_address_in == ACR_OFS_CUT_LO && avs_byteenable_in[1:0] == 2'h3
    |=> cutoff_ch0_7_r == $past(avs_writedata_in[15:0]))
    else $error("cutoff_ch0_7 write lost");
  chk_cut_hi_write: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    wr_go && avs_address_in == ACR_OFS_CUT_HI && avs_byteenable_in[1:0] == 2'h3
    |=> cutoff_ch8_15_r == $past(avs_writedata_in[15:0]))
    else $error("cutoff_ch8_15 write lost");
  chk_bs_readback: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    avs_read_in && !ack_r && avs_address_in == ACR_OFS_BUF_SIZE
    |=> !avs_waitrequest_out && avs_readdata_out == {16'h0000, sample_buffer_size_r})
    else $error("buffer size readback wrong");
  chk_bs_valid: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    ##1 buffer_size_valid_out == ($past(sample_buffer_size_r[4:0]) <= 5'h16))
    else $error("buffer size validity wrong");
  chk_gain_reset: assert property (@(posedge mclk_in)
    $rose(rst_b_in) |-> gain_ch0_7_r == 16'h0000 && gain_ch8_15_r == 16'h0000)
    else $error("gain not reset");
  chk_cut_reset: assert property (@(posedge mclk_in)
    $rose(rst_b_in) |-> cutoff_ch0_7_r == 16'h0000 && cutoff_ch8_15_r == 16'h0000)
    else $error("cutoff not reset");
  chk_front_follow: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    gain_ch0_7_r[1:0] == 2'h1 ##1 gain_ch0_7_r[1:0] == 2'h1 |-> gain_sel_out[3:0] == 4'h2)
    else $error("front end gain not following");

  // ----------------------------------------------------------------
  // checks: bus handshake and read path
  // ----------------------------------------------------------------
  chk_wait_answer: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    req && !ack_r |=> !avs_waitrequest_out && ack_r)
    else $error("no answer after one wait cycle");

  chk_wait_single: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    !avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low too long");

  chk_wait_idle: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    !req |=> avs_waitrequest_out)
    else $error("answer without request");

  chk_wr_once: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    wr_go |=> !wr_go)
    else $error("write applied twice");

  chk_rd_upper: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    avs_readdata_out[31:16] == 16'h0000)
    else $error("read data upper half not zero");

  chk_rd_hold: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    !(avs_read_in && !ack_r) |=> $stable(avs_readdata_out))
    else $error("read data changed without read");

  chk_unmapped_read: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    avs_read_in && !ack_r && !hit |=> avs_readdata_out == 32'h0000_0000)
    else $error("unmapped read not zero");

  chk_gain_lo_read: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    avs_read_in && !ack_r && avs_address_in == ACR_OFS_GAIN_LO
    |=> avs_readdata_out == {16'h0000, $past(gain_ch0_7_r)})
    else $error("gain_ch0_7 readback wrong");

  chk_gain_hi_read: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    avs_read_in && !ack_r && avs_address_in == ACR_OFS_GAIN_HI
    |=> avs_readdata_out == {16'h0000, $past(gain_ch8_15_r)})
    else $error("gain_ch8_15 readback wrong");

  chk_cut_lo_read: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    avs_read_in && !ack_r && avs_address_in == ACR_OFS_CUT_LO
    |=> avs_readdata_out == {16'h0000, $past(cutoff_ch0_7_r)})
    else $error("cutoff_ch0_7 readback wrong");

  chk_cut_hi_read: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    avs_read_in && !ack_r && avs_address_in == ACR_OFS_CUT_HI
    |=> avs_readdata_out == {16'h0000, $past(cutoff_ch8_15_r)})
    else $error("cutoff_ch8_15 readback wrong");

  // ----------------------------------------------------------------
  // checks: registers change only on their own write
  // ----------------------------------------------------------------
  chk_gain_lo_hold: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    !(wr_go && avs_address_in == ACR_OFS_GAIN_LO) |=> $stable(gain_ch0_7_r))
    else $error("gain_ch0_7 changed without write");

  chk_gain_hi_hold: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    !(wr_go && avs_address_in == ACR_OFS_GAIN_HI) |=> $stable(gain_ch8_15_r))
    else $error("gain_ch8_15 changed without write");

  chk_cut_lo_hold: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    !(wr_go && avs_address_in == ACR_OFS_CUT_LO) |=> $stable(cutoff_ch0_7_r))
    else $error("cutoff_ch0_7 changed without write");

  chk_cut_hi_hold: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    !(wr_go && avs_address_in == ACR_OFS_CUT_HI) |=> $stable(cutoff_ch8_15_r))
    else $error("cutoff_ch8_15 changed without write");

  chk_bs_hold: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    !(wr_go && avs_address_in == ACR_OFS_BUF_SIZE) |=> $stable(sample_buffer_size_r))
    else $error("sample_buffer_size changed without write");

  chk_bs_write: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    wr_go && avs_address_in == ACR_OFS_BUF_SIZE && avs_byteenable_in[1:0] == 2'h3
    |=> sample_buffer_size_r == $past(avs_writedata_in[15:0]))
    else $error("sample_buffer_size write lost");

  chk_lane_keep: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    wr_go && avs_address_in == ACR_OFS_GAIN_LO && avs_byteenable_in[1:0] == 2'h2
    |=> gain_ch0_7_r == {$past(avs_writedata_in[15:8]), $past(gain_ch0_7_r[7:0])})
    else $error("byte lane merge wrong");

  // ----------------------------------------------------------------
  // checks: scan buffer and front end
  // ----------------------------------------------------------------
  chk_bs_code: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    1'b1 |=> buffer_size_code_out == $past(sample_buffer_size_r[ACR_BS_W-1:0]))
    else $error("buffer size code not passed on");

  chk_bs_flag: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    buffer_size_valid_out == (buffer_size_code_out <= ACR_BS_MAX))
    else $error("buffer size flag disagrees with code");

  chk_bs_reset: assert property (@(posedge mclk_in)
    $rose(rst_b_in) |-> sample_buffer_size_r == {11'h000, ACR_RST_BS} && buffer_size_valid_out)
    else $error("buffer size not reset");

  chk_sel_reset: assert property (@(posedge mclk_in)
    $rose(rst_b_in) |-> gain_sel_out == {16{ACR_GAIN_X1}}
    && cutoff_sel_out == {16{ACR_CUT_1000HZ}})
    else $error("front end selects not reset");

  chk_front_cut: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    1'b1 |=> cutoff_sel_out[3:0] == (4'h1 << $past(cutoff_ch0_7_r[1:0])))
    else $error("front end cutoff not following");

  chk_front_hi: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    1'b1 |=> gain_sel_out[63:60] == (4'h1 << $past(gain_ch8_15_r[15:14])))
    else $error("front end gain ch15 not following");

  chk_gain_ch7: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    1'b1 |=> gain_sel_out[31:28] == (4'h1 << $past(gain_ch0_7_r[15:14])))
    else $error("gain ch7 field misplaced");

  chk_gain_ch8: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    1'b1 |=> gain_sel_out[35:32] == (4'h1 << $past(gain_ch8_15_r[1:0])))
    else $error("gain ch8 field misplaced");

  chk_cut_ch7: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    1'b1 |=> cutoff_sel_out[31:28] == (4'h1 << $past(cutoff_ch0_7_r[15:14])))
    else $error("cutoff ch7 field misplaced");

  chk_cut_ch8: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    1'b1 |=> cutoff_sel_out[35:32] == (4'h1 << $past(cutoff_ch8_15_r[1:0])))
    else $error("cutoff ch8 field misplaced");

endmodule // acr_regs

// >>> sim/acr_regs_tb_top.sv
// acr_regs_tb_top: self-checking bench for the channel config register bank
// assumes: acr_pkg and acr_regs compiled first, one 125 MHz clock
module acr_regs_tb_top
  import acr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic mclk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [7:0] avs_address_in = 8'h00;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [3:0] avs_byteenable_in = 4'hF;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out;
  logic [63:0] gain_sel_out;
  logic [63:0] cutoff_sel_out;
  logic [4:0] buffer_size_code_out;
  logic buffer_size_valid_out;
  int fails = 0;
  int checked = 0;
  int cycles = 0;
  logic [63:0] exp_g = {16{4'h1}};
  logic [63:0] exp_c = {16{4'h1}};

  always #4 mclk_in = ~mclk_in;

  acr_regs dut (
    .mclk_in(mclk_in),
    .rst_b_in(rst_b_in),
    .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out),
    .gain_sel_out(gain_sel_out),
    .cutoff_sel_out(cutoff_sel_out),
    .buffer_size_code_out(buffer_size_code_out),
    .buffer_size_valid_out(buffer_size_valid_out)
  );

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic print_verdict;
    if (fails == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      $display("unexpected %s expected %h seen %h", what, exp, seen);
      fails++;
    end
  endtask

  // one-hot select per channel, eight channels of one register
  function automatic logic [31:0] onehot8(input logic [15:0] c);
    logic [31:0] r;
    for (int i = 0; i < 8; i++) r[4*i+:4] = 4'h1 << c[2*i+:2];
    return r;
  endfunction

  // one avalon cycle; holds until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d,
                     input logic [3:0] b, output logic [31:0] q);
    int n;
    @(posedge mclk_in);
    avs_address_in <= a;
    avs_writedata_in <= {16'h0, d};
    avs_byteenable_in <= b;
    avs_write_in <= w;
    avs_read_in <= !w;
    n = 0;
    do begin
      @(posedge mclk_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0);
    q = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    check("wait states", 64'(n), 64'(ACR_WAIT_CYC + 1));
  endtask

  task automatic settle;
    repeat (2) @(posedge mclk_in);
    #1;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    logic [31:0] q;
    check("gain_sel", gain_sel_out, exp_g);
    check("cutoff_sel", cutoff_sel_out, exp_c);
    check("bs_valid", 64'(buffer_size_valid_out), 64'h1);
    check("bs_code", 64'(buffer_size_code_out), 64'h0);
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, 8'h10 + 8'(2 * i), 16'h0, 4'h3, q);
      check("reset read", 64'(q), 64'h0);
    end
  endtask

  task automatic t_fields;
    logic [15:0] pat [4] = '{16'hE4E5, 16'h1B1B, 16'h1B1B, 16'hE4E4};
    logic [31:0] q;
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 8'h10 + 8'(2 * i), pat[i], 4'h3, q);
      bus(1'b0, 8'h10 + 8'(2 * i), 16'h0, 4'h3, q);
      check("field read", 64'(q), {48'h0, pat[i]});
      if (i < 2) exp_g[32*i+:32] = onehot8(pat[i]);
      else exp_c[32*(i-2)+:32] = onehot8(pat[i]);
      settle();
      check("gain_sel", gain_sel_out, exp_g);
      check("cutoff_sel", cutoff_sel_out, exp_c);
    end
    bus(1'b1, ACR_OFS_GAIN_LO, 16'h0000, 4'h2, q);
    bus(1'b0, ACR_OFS_GAIN_LO, 16'h0, 4'h3, q);
    check("lane write", 64'(q), 64'h00E5);
    exp_g[31:0] = onehot8(16'h00E5);
    settle();
    check("gain_sel lane", gain_sel_out, exp_g);
  endtask

  task automatic t_bufsize;
    logic [15:0] v [4] = '{16'h0016, 16'h0017, 16'h001F, 16'h0000};
    logic [31:0] q;
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, ACR_OFS_BUF_SIZE, v[i], 4'h3, q);
      bus(1'b0, ACR_OFS_BUF_SIZE, 16'h0, 4'h3, q);
      check("size read", 64'(q), {48'h0, v[i]});
      #1;
      check("size code", 64'(buffer_size_code_out), 64'(v[i][4:0]));
      check("size valid", 64'(buffer_size_valid_out), 64'(v[i][4:0] <= 5'h16));
    end
  endtask

  task automatic t_unmapped;
    logic [31:0] q;
    bus(1'b1, 8'h1A, 16'hABCD, 4'h3, q);
    bus(1'b0, 8'h1A, 16'h0, 4'h3, q);
    check("unmapped read", 64'(q), 64'h0);
    bus(1'b0, ACR_OFS_CUT_HI, 16'h0, 4'h3, q);
    check("cut hi kept", 64'(q), 64'hE4E4);
  endtask

  task automatic t_nofilter;
    logic [31:0] q;
    bus(1'b1, ACR_OFS_CUT_LO, 16'h0000, 4'h3, q);
    bus(1'b1, ACR_OFS_CUT_HI, 16'h0000, 4'h3, q);
    bus(1'b0, ACR_OFS_CUT_LO, 16'h0, 4'h3, q);
    check("cut lo zero", 64'(q), 64'h0);
    bus(1'b0, ACR_OFS_CUT_HI, 16'h0, 4'h3, q);
    check("cut hi zero", 64'(q), 64'h0);
    settle();
    check("cutoff_sel", cutoff_sel_out, {16{4'h1}});
  endtask

  // ----------------------------------------------------------------
  // main sequence and timeout
  // ----------------------------------------------------------------
  always @(posedge mclk_in) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails++;
      print_verdict();
    end
  end

  initial begin
    repeat (12) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    @(posedge mclk_in);
    #1;
    t_reset();
    t_fields();
    t_bufsize();
    t_unmapped();
    t_nofilter();
    print_verdict();
  end
endmodule // acr_regs_tb_top
